// File: design/spme_entry.sv
`timescale 1ns/1ns
// Overview of operation
// - Serial clock pin is input only; data pin is bidirectional during sessions.
// - In a session, memory, IDs and config are reached only via the serial link.
// - High-voltage entry: clock and data low, then master clear raised to high voltage.
// - Low-voltage entry accepted only when low-voltage enable bit is 1.
// - Low-voltage entry: master clear low, then 32 key bits clocked in.
// - Low-voltage session lasts only while master clear stays low.
// - Low-voltage enable set forces master clear reset function on.
// - Low-voltage enable may be cleared only in a high-voltage session.
module spme_entry
  import spme_pkg::*;
#(
  parameter logic [31:0] ENTRY_KEY = spme_pkg::KEY_DEFAULT
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_n,
  input wire logic master_clear_pin_n,
  input wire logic vpp_high_detect,
  input wire logic master_clear_reset_cfg,
  input wire logic lv_enable_wr_valid,
  input wire logic lv_enable_wr_value,
  input wire logic tx_drive,
  input wire logic tx_bit,
  output logic prog_mode,
  output logic prog_mode_hv,
  output logic prog_mode_lv,
  output logic core_access_block,
  output logic low_voltage_prog_enable,
  output logic master_clear_reset_enable,
  output logic lv_enable_wr_refused
);
  import spme_pkg::*;

  // ==========================================================
  // Link-clock domain: key capture
  spme_core_t core_reg;
  spme_core_t core_next;
  spme_link_t link_reg;
  spme_link_t link_next;
  logic link_clear;
  logic [31:0] shifted;

  // Held clear from a core flop whenever no key is awaited; the programmer
  // keeps the clock still while master clear falls, so release is quiet.
  assign link_clear = (core_reg.state != SPME_LV_KEY);

  always_comb
  begin
    link_next = link_reg;
    shifted = {link_reg.shift[30:0], prog_serial_data_in};
    if (!link_reg.done)
    begin
      link_next.shift = shifted;
      link_next.count = link_reg.count + 6'h01;
      if (link_reg.count == KEY_COUNT_LAST)
      begin
        link_next.done = 1'b1;
        link_next.match = (shifted == ENTRY_KEY);
      end
    end
  end

  // Clock pin clocks this capture and is also sampled by the core for high-voltage entry; it is never driven
  always_ff @(posedge prog_serial_clock or posedge link_clear)
  begin
    if (link_clear)
      link_reg <= LINK_RESET;
    else
      link_reg <= link_next;
  end

  // ==========================================================
  // Core-clock domain: pin sync and session control
  logic master_clear_n_s;
  logic hv_s;
  logic pins_low;
  logic done_s;

  assign master_clear_n_s = core_reg.master_clear_n_sync[1];
  assign hv_s = core_reg.hv_sync[1];
  assign pins_low = !core_reg.clk_pin_sync[1] && !core_reg.dat_pin_sync[1];
  assign done_s = core_reg.done_sync[1];

  always_comb
  begin
    core_next = core_reg;
    core_next.master_clear_n_sync = {core_reg.master_clear_n_sync[0], master_clear_pin_n};
    core_next.hv_sync = {core_reg.hv_sync[0], vpp_high_detect};
    core_next.clk_pin_sync = {core_reg.clk_pin_sync[0], prog_serial_clock};
    core_next.dat_pin_sync = {core_reg.dat_pin_sync[0], prog_serial_data_in};
    core_next.done_sync = {core_reg.done_sync[0], link_reg.done};
    core_next.hv_prev = hv_s;
    core_next.wr_refused = 1'b0;
    case (core_reg.state)
      SPME_IDLE:
      begin
        if (hv_s && !core_reg.hv_prev && pins_low)
          core_next.state = SPME_HV_SESS;
        else if (!master_clear_n_s && core_reg.lv_enable)
          core_next.state = SPME_LV_KEY;
      end
      SPME_LV_KEY:
      begin
        // Link word is stable once done has crossed, so match is safe to read
        if (master_clear_n_s)
          core_next.state = SPME_IDLE;
        else if (done_s)
          core_next.state = link_reg.match ? SPME_LV_SESS : SPME_LV_FAIL;
      end
      SPME_LV_FAIL:
      begin
        if (master_clear_n_s)
          core_next.state = SPME_IDLE;
      end
      SPME_LV_SESS:
      begin
        if (master_clear_n_s)
          core_next.state = SPME_IDLE;
      end
      SPME_HV_SESS:
      begin
        if (!hv_s)
          core_next.state = SPME_IDLE;
      end
      default:
      begin
        core_next.state = SPME_IDLE;
      end
    endcase
    if (lv_enable_wr_valid && (core_reg.state == SPME_LV_SESS ||
        core_reg.state == SPME_HV_SESS))
    begin
      if (lv_enable_wr_value || core_reg.state == SPME_HV_SESS)
        core_next.lv_enable = lv_enable_wr_value;
      else
        core_next.wr_refused = 1'b1;
    end
    // Data pin driven only while a session is open and reads are shifted out
    core_next.dat_oe_n = !(tx_drive && (core_reg.state == SPME_LV_SESS ||
                           core_reg.state == SPME_HV_SESS));
    core_next.dat_out = tx_bit;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      core_reg <= CORE_RESET;
    else if (clk_en)
      core_reg <= core_next;
  end

  // ==========================================================
  // Outputs
  assign prog_mode_hv = (core_reg.state == SPME_HV_SESS);
  assign prog_mode_lv = (core_reg.state == SPME_LV_SESS);
  assign prog_mode = prog_mode_hv || prog_mode_lv;
  assign core_access_block = prog_mode;
  assign low_voltage_prog_enable = core_reg.lv_enable;
  assign master_clear_reset_enable = core_reg.lv_enable || master_clear_reset_cfg;
  assign lv_enable_wr_refused = core_reg.wr_refused;
  assign prog_serial_data_out = core_reg.dat_out;
  assign prog_serial_data_oe_n = core_reg.dat_oe_n;

endmodule : spme_entry

// File: design/spme_pkg.sv
package spme_pkg;

  // ==========================================================
  // Entry key and configuration defaults
  localparam int KEY_BITS = 32;
  localparam logic [31:0] KEY_DEFAULT = 32'ha5c3_0f69;
  localparam logic LV_ENABLE_RESET = 1'b1;
  localparam logic [5:0] KEY_COUNT_LAST = 6'h1f;

  // ==========================================================
  // Session states
  typedef enum logic [2:0] {
    SPME_IDLE = 3'b000,
    SPME_LV_KEY = 3'b001,
    SPME_LV_FAIL = 3'b010,
    SPME_LV_SESS = 3'b011,
    SPME_HV_SESS = 3'b100
  } spme_state_t;

  // ==========================================================
  // State of the core-clock logic
  typedef struct packed {
    spme_state_t state;
    logic [1:0] master_clear_n_sync;
    logic [1:0] hv_sync;
    logic [1:0] clk_pin_sync;
    logic [1:0] dat_pin_sync;
    logic [1:0] done_sync;
    logic hv_prev;
    logic lv_enable;
    logic wr_refused;
    logic dat_out;
    logic dat_oe_n;
  } spme_core_t;

  // State of the link-clock logic
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] count;
    logic done;
    logic match;
  } spme_link_t;

  localparam spme_core_t CORE_RESET = '{
    state: SPME_IDLE,
    master_clear_n_sync: 2'h3,
    hv_sync: 2'h0,
    clk_pin_sync: 2'h0,
    dat_pin_sync: 2'h0,
    done_sync: 2'h0,
    hv_prev: 1'b0,
    lv_enable: LV_ENABLE_RESET,
    wr_refused: 1'b0,
    dat_out: 1'b0,
    dat_oe_n: 1'b1
  };

  localparam spme_link_t LINK_RESET = '{
    shift: 32'h0000_0000,
    count: 6'h00,
    done: 1'b0,
    match: 1'b0
  };

endpackage : spme_pkg

// File: testbench/spme_sva.sv
`timescale 1ns/1ns
module spme_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic master_clear_pin_n,
  input wire logic lv_enable_wr_valid,
  input wire logic lv_enable_wr_value,
  input wire logic tx_drive,
  input wire logic tx_bit,
  input wire logic prog_serial_data_out,
  input wire logic prog_serial_data_oe_n,
  input wire logic prog_mode,
  input wire logic prog_mode_hv,
  input wire logic prog_mode_lv,
  input wire logic core_access_block,
  input wire logic low_voltage_prog_enable,
  input wire logic master_clear_reset_enable,
  input wire logic lv_enable_wr_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_clr(m); lv_enable_wr_valid && !lv_enable_wr_value && m; endsequence
  // Four cycles covers the two-flop sync plus the state update
  sequence s_clear_up; prog_mode_lv ##1 master_clear_pin_n [*4]; endsequence
  a_reset_forced: assert property (low_voltage_prog_enable |-> master_clear_reset_enable)
    else $error("master clear reset off");
  a_link_only: assert property (core_access_block == prog_mode)
    else $error("access block");
  a_lv_refuse: assert property (s_clr(prog_mode_lv)
    |=> lv_enable_wr_refused && low_voltage_prog_enable) else $error("lv clear");
  a_hv_clear: assert property (s_clr(prog_mode_hv) |=> !low_voltage_prog_enable)
    else $error("hv clear");
  a_lv_gate: assert property (!low_voltage_prog_enable && !prog_mode_lv |=> !prog_mode_lv)
    else $error("lv gate");
  a_lv_exit: assert property (s_clear_up |=> !prog_mode_lv)
    else $error("lv exit");
  a_oe_idle: assert property (!prog_mode |=> prog_serial_data_oe_n)
    else $error("oe idle");
  a_tx_bit: assert property (tx_drive && prog_mode
    |=> !prog_serial_data_oe_n && prog_serial_data_out == $past(tx_bit)) else $error("tx");
endmodule : spme_sva

// File: testbench/spme_prog_model.sv
`timescale 1ns/1ns
module spme_prog_model (
  output logic prog_serial_clock,
  output logic model_data,
  output logic master_clear_pin_n,
  output logic vpp_high_detect
);
  initial
  begin
    prog_serial_clock = 1'b0;
    model_data = 1'b0;
    master_clear_pin_n = 1'b1;
    vpp_high_detect = 1'b0;
  end
  // Link clock runs only inside a key frame
  task automatic lv_entry(input logic [31:0] k, input int n);
    master_clear_pin_n = 1'b0;
    #40;
    for (int i = 31; i > 31 - n; i--)
    begin
      model_data = k[i];
      #6 prog_serial_clock = 1'b1;
      #6 prog_serial_clock = 1'b0;
    end
    model_data = 1'b0;
  endtask : lv_entry
  task automatic hv(input logic on);
    model_data = 1'b0;
    vpp_high_detect = on;
  endtask : hv
endmodule : spme_prog_model

// File: testbench/spme_entry_tb_top.sv
`timescale 1ns/1ns
module spme_entry_tb_top;
  import spme_pkg::*;
  localparam logic [31:0] KEY = 32'h3c96_5ae1;
  logic clock = 1'b0, srst = 1'b1, clk_en = 1'b1, tx_bit = 1'b0;
  logic master_clear_reset_cfg = 1'b0;
  logic lv_enable_wr_valid = 1'b0, lv_enable_wr_value = 1'b0, tx_drive = 1'b0;
  logic prog_serial_clock, model_data, master_clear_pin_n, vpp_high_detect, prog_mode;
  logic prog_serial_data_out, prog_serial_data_oe_n, prog_mode_hv, prog_mode_lv;
  logic core_access_block, low_voltage_prog_enable, master_clear_reset_enable;
  logic lv_enable_wr_refused;
  wire logic prog_serial_data_in = prog_serial_data_oe_n ? model_data : prog_serial_data_out;
  int num_errors = 0, n_compared = 0, seed = 32'hb515, cycles = 0;
  spme_entry #(.ENTRY_KEY(KEY)) i_spme_entry (.*);
  spme_prog_model i_spme_prog_model (.*);
  always #2 clock = ~clock;
  always @(posedge clock)
    if (++cycles > 5000)
      finish_test(1);
  task automatic check(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic wr(input logic v);
    lv_enable_wr_valid = 1'b1;
    lv_enable_wr_value = v;
    step(1);
    lv_enable_wr_valid = 1'b0;
  endtask : wr
  task automatic finish_test(input int extra);
    num_errors += extra;
    $display("Compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  initial
  begin
    step(6);
    srst = 1'b0;
    check("lv enable reset", low_voltage_prog_enable, LV_ENABLE_RESET);
    for (int i = 0; i < 4; i++)
    begin
      // Wrong key, short key, good key, good key with entry disabled
      // Unsigned pick keeps the flipped bit inside the key, so it always differs
      i_spme_prog_model.lv_entry(i == 0 ? KEY ^ (32'h1 << ($unsigned($random(seed)) % 32)) : KEY,
        i == 1 ? 16 : 32);
      step(8);
      check("lv mode", prog_mode_lv, i > 1 && low_voltage_prog_enable);
      if (i == 2)
      begin
        check("access", core_access_block, 1'b1);
        wr(1'b0);
        check("refused", lv_enable_wr_refused, 1'b1);
        check("reset forced", master_clear_reset_enable, 1'b1);
        tx_drive = 1'b1;
        tx_bit = 1'($random(seed));
        step(1);
        check("tx out", prog_serial_data_out, tx_bit);
        tx_drive = 1'b0;
      end
      i_spme_prog_model.master_clear_pin_n = 1'b1;
      step(6);
      check("lv exit", prog_mode_lv, 1'b0);
      if (i == 2)
      begin
        i_spme_prog_model.hv(1'b1);
        step(6);
        check("hv mode", prog_mode_hv, 1'b1);
        wr(1'b0);
        master_clear_reset_cfg = 1'($random(seed));
        step(1);
        check("lv enable clr", low_voltage_prog_enable, 1'b0);
        check("reset cfg", master_clear_reset_enable, master_clear_reset_cfg);
        i_spme_prog_model.hv(1'b0);
        step(6);
      end
    end
    finish_test(0);
  end
endmodule : spme_entry_tb_top
bind spme_entry spme_sva i_spme_sva (.*);
